// File: rtl/msrp_pkg.sv
package msrp_pkg;

	// Widths of the software word, the word address and the full result.
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned RES_W  = 64;
	localparam int unsigned CNT_W  = 4;

	// Word addresses on the register port.
	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_RESULT_WORD_0     = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_RESULT_WORD_1     = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_RESULT_WORD_2     = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_RESULT_WORD_3     = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_SIGN_EXTENSION_WORD   = 3'h5;
	localparam logic [ADDR_W-1:0] ADDR_OP2_LOW  = 3'h6;
	localparam logic [ADDR_W-1:0] ADDR_OP2_HIGH = 3'h7;

	// Bit positions inside multiplier_control_0.
	localparam int unsigned CTRL_SAT     = 0;
	localparam int unsigned CTRL_FRAC    = 1;
	localparam int unsigned CTRL_CARRY   = 2;
	localparam int unsigned CTRL_ACC     = 3;
	localparam int unsigned CTRL_SIZE_LO = 4;
	localparam int unsigned CTRL_SIZE_HI = 5;
	localparam int unsigned CTRL_READY   = 6;

	// Operand size combinations, first operand by second operand.
	typedef enum logic [1:0] {
		MSRP_SZ_16X16 = 2'b00,
		MSRP_SZ_32X16 = 2'b01,
		MSRP_SZ_16X32 = 2'b10,
		MSRP_SZ_32X32 = 2'b11
	} msrp_size_t;

	// Clock counts from the last operand write until all words are valid.
	localparam logic [CNT_W-1:0] LAT_16X16      = 4'h3;
	localparam logic [CNT_W-1:0] LAT_32X16      = 4'h7;
	localparam logic [CNT_W-1:0] LAT_16X32_LOW  = 4'h7;
	localparam logic [CNT_W-1:0] LAT_16X32_HIGH = 4'h4;
	localparam logic [CNT_W-1:0] LAT_32X32_LOW  = 4'hb;
	localparam logic [CNT_W-1:0] LAT_32X32_HIGH = 4'h6;
	localparam logic [CNT_W-1:0] CNT_ZERO       = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE        = 4'h1;

	// Clamp patterns.
	localparam logic [DATA_W-1:0] POS_TOP  = 16'h7fff;
	localparam logic [DATA_W-1:0] NEG_TOP  = 16'h8000;
	localparam logic [DATA_W-1:0] ALL_ONES = 16'hffff;
	localparam logic [DATA_W-1:0] ALL_ZERO = 16'h0000;

	// Reset values.
	localparam logic [RES_W-1:0]  RES_RESET  = 64'h0;
	localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;

endpackage : msrp_pkg

// File: rtl/msrp_if.sv
`timescale 1ns/1ns
interface msrp_if;
	import msrp_pkg::*;

	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] rdata;

	// Device end answers reads; host end issues strobes.
	modport device (input addr, input wdata, input wr, input rd,
		output rdata);
	modport host (output addr, output wdata, output wr, output rd,
		input rdata);
endinterface : msrp_if

// File: rtl/msrp_device.sv
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ns
//Contract
// RL1: Clamp only while saturate_enable is set.
// RL2: Overflow presents the most positive value.
// RL3: Underflow presents the most negative value.
// RL4: Stored result words are never rewritten.
// RL5: Accumulate input uses the clamped result.
// RL6: 16x16 clamps only result words 0 and 1.
// RL7: Software never mixes sizes when accumulating saturated.
// RL8: 32-bit operand clamp waits for word 3.
// RL9: Sign extension and carry stay unsaturated.
// RL10: Words valid at fixed counts after operand.
// RL11: Decision uses carry, top bit, fractional bits.
// RL12: 32-bit: carry 0, bit15 1 is overflow.
// RL13: 32-bit: carry 1, bit15 0 is underflow.
// RL14: 64-bit tests use word 3 bit 15.
// RL15: Fractional: top bits 01 overflow, 10 underflow.
// RL16: Fractional minus one squared saturates positive.
// RL17: Software keeps results unchanged until read.
// RL18: Preloads also set carry to the sign.
// RL19: Software enables saturation only when needed.
// RL20: Fractional reads are shifted left one bit.
// RL21: Carry always reports the non-fractional carry.
// RL22: Clamp is combinational on read and feedback.
module msrp_device (
	input  wire logic                   i_clk,
	input  wire logic                   i_reset,
	msrp_if.device                      bus,
	input  wire logic                   i_res_valid,
	input  wire logic [msrp_pkg::RES_W-1:0]  i_res_value,
	input  wire logic                   i_res_carry,
	input  wire logic [msrp_pkg::DATA_W-1:0] i_res_sign_extension_word,
	output logic                        o_start,
	output logic                        o_start_high,
	output logic [msrp_pkg::DATA_W-1:0] o_op_word,
	output logic                        o_accumulate,
	output msrp_pkg::msrp_size_t        o_size,
	output logic [msrp_pkg::RES_W-1:0]  o_acc_feed
);
	import msrp_pkg::*;

	// Flags are {overflow, underflow}; the top word is word 1 or word 3.
	function automatic logic [1:0] sat_eval(input logic [RES_W-1:0] res,
		input logic carry, input logic frac, input logic wide);
		logic [DATA_W-1:0] top;
		logic [1:0]        flags;
		top = wide ? res[63:48] : res[31:16]; // RL14 RL6
		flags = 2'b00;
		if (!carry && top[15]) begin // RL11 RL12
			flags = 2'b10;
		end else if (carry && !top[15]) begin // RL13
			flags = 2'b01;
		end else if (frac && !top[15] && top[14]) begin // RL15 RL16
			flags = 2'b10;
		end else if (frac && top[15] && !top[14]) begin // RL15
			flags = 2'b01;
		end
		return flags;
	endfunction : sat_eval

	// Narrow clamps leave words 2 and 3 as they are.
	function automatic logic [RES_W-1:0] sat_clamp(
		input logic [RES_W-1:0] res, input logic [1:0] flags,
		input logic wide);
		logic [RES_W-1:0] v;
		v = res;
		if (flags[1]) begin // RL2
			v = wide ? {POS_TOP, ALL_ONES, ALL_ONES, ALL_ONES}
				: {res[63:32], POS_TOP, ALL_ONES}; // RL6 RL12 RL14
		end else if (flags[0]) begin // RL3
			v = wide ? {NEG_TOP, ALL_ZERO, ALL_ZERO, ALL_ZERO}
				: {res[63:32], NEG_TOP, ALL_ZERO}; // RL6 RL13 RL14
		end
		return v;
	endfunction : sat_clamp

	// Latency of a start write, zero when the write starts nothing.
	function automatic logic [CNT_W-1:0] start_lat(input msrp_size_t sz,
		input logic high);
		logic [CNT_W-1:0] lat;
		lat = CNT_ZERO;
		unique case (sz)
			MSRP_SZ_16X16: lat = high ? CNT_ZERO : LAT_16X16;
			MSRP_SZ_32X16: lat = high ? CNT_ZERO : LAT_32X16;
			MSRP_SZ_16X32: lat = high ? LAT_16X32_HIGH : LAT_16X32_LOW;
			MSRP_SZ_32X32: lat = high ? LAT_32X32_HIGH : LAT_32X32_LOW;
		endcase
		return lat; // RL10
	endfunction : start_lat

	logic                  sat;
	logic                  frac;
	logic                  carry;
	logic                  acc;
	msrp_size_t            size;
	logic [RES_W-1:0]      res;
	logic [DATA_W-1:0]     sign_extension_word;
	logic [CNT_W-1:0]      cnt;
	logic [DATA_W-1:0]     rdata;
	logic                  next_sat;
	logic                  next_frac;
	logic                  next_carry;
	logic                  next_acc;
	msrp_size_t            next_size;
	logic [RES_W-1:0]      next_res;
	logic [DATA_W-1:0]     next_sign_extension_word;
	logic [CNT_W-1:0]      next_cnt;
	logic [DATA_W-1:0]     next_rdata;
	logic                  next_start;
	logic                  next_start_high;
	logic [DATA_W-1:0]     next_op_word;
	logic [RES_W-1:0]      next_acc_feed;
	logic                  wide;
	logic                  ready;
	logic [1:0]            rd_flags;
	logic                  sat_live;
	logic [RES_W-1:0]      shifted;
	logic [RES_W-1:0]      view;
	logic [CNT_W-1:0]      lat;
	logic                  new_wide;
	logic                  is_start;

	// Read view: the stored words are only looked at, never altered, so
	// clearing both enables shows the raw result again on the next read.
	always_comb begin
		wide = (size != MSRP_SZ_16X16);
		ready = (cnt == CNT_ZERO);
		rd_flags = sat_eval(res, carry, frac, wide); // RL22
		sat_live = sat && (!wide || ready) && (rd_flags != 2'b00); // RL1 RL8
		shifted = frac ? {res[RES_W-2:0], 1'b0} : res; // RL20
		view = sat_live ? sat_clamp(shifted, rd_flags, wide) : shifted; // RL4
	end

	// Register writes, start decode, read answer and accumulate feed.
	always_comb begin
		next_sat = sat;
		next_frac = frac;
		next_carry = carry;
		next_acc = acc;
		next_size = size;
		next_res = res;
		next_sign_extension_word = sign_extension_word;
		next_cnt = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_ONE;
		next_rdata = WORD_RESET;
		next_start = 1'b0;
		next_start_high = 1'b0;
		next_op_word = o_op_word;
		next_acc_feed = o_acc_feed;
		lat = CNT_ZERO;
		is_start = 1'b0;
		new_wide = (size != MSRP_SZ_16X16);
		if (bus.wr) begin
			unique case (bus.addr)
				ADDR_CTRL: begin
					next_sat = bus.wdata[CTRL_SAT];
					next_frac = bus.wdata[CTRL_FRAC];
					next_carry = bus.wdata[CTRL_CARRY];
					next_acc = bus.wdata[CTRL_ACC];
					next_size = msrp_size_t'(
						bus.wdata[CTRL_SIZE_HI:CTRL_SIZE_LO]);
				end
				ADDR_RESULT_WORD_0: next_res[15:0] = bus.wdata;
				ADDR_RESULT_WORD_1: next_res[31:16] = bus.wdata;
				ADDR_RESULT_WORD_2: next_res[47:32] = bus.wdata;
				ADDR_RESULT_WORD_3: next_res[63:48] = bus.wdata;
				ADDR_SIGN_EXTENSION_WORD: next_sign_extension_word = bus.wdata;
				ADDR_OP2_LOW, ADDR_OP2_HIGH: begin
					lat = start_lat(size, bus.addr == ADDR_OP2_HIGH);
					is_start = (lat != CNT_ZERO);
				end
			endcase
		end
		// A new operation launches; with saturation on, the feed is clamped for its size.
		if (is_start) begin
			next_cnt = lat; // RL10
			next_start = 1'b1;
			next_start_high = (bus.addr == ADDR_OP2_HIGH);
			next_op_word = bus.wdata;
			next_acc_feed = res;
			if (sat) begin // RL5
				next_acc_feed = sat_clamp(res,
					sat_eval(res, carry, 1'b0, new_wide), new_wide);
			end
		end
		// The datapath result wins over a software preload in one cycle.
		if (i_res_valid) begin
			next_res = i_res_value;
			next_carry = i_res_carry; // RL21
			next_sign_extension_word = i_res_sign_extension_word;
		end
		if (bus.rd) begin
			unique case (bus.addr)
				ADDR_CTRL: begin
					next_rdata[CTRL_SAT] = sat;
					next_rdata[CTRL_FRAC] = frac;
					next_rdata[CTRL_CARRY] = carry; // RL9
					next_rdata[CTRL_ACC] = acc;
					next_rdata[CTRL_SIZE_HI:CTRL_SIZE_LO] = size;
					next_rdata[CTRL_READY] = ready;
				end
				ADDR_RESULT_WORD_0: next_rdata = view[15:0];
				ADDR_RESULT_WORD_1: next_rdata = view[31:16];
				ADDR_RESULT_WORD_2: next_rdata = view[47:32];
				ADDR_RESULT_WORD_3: next_rdata = view[63:48];
				ADDR_SIGN_EXTENSION_WORD: next_rdata = sign_extension_word; // RL9
				ADDR_OP2_LOW, ADDR_OP2_HIGH: next_rdata = WORD_RESET;
			endcase
		end
	end

	// State registers.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sat <= 1'b0;
			frac <= 1'b0;
			carry <= 1'b0;
			acc <= 1'b0;
			size <= MSRP_SZ_16X16;
			res <= RES_RESET;
			sign_extension_word <= WORD_RESET;
			cnt <= CNT_ZERO;
			rdata <= WORD_RESET;
			o_start <= 1'b0;
			o_start_high <= 1'b0;
			o_op_word <= WORD_RESET;
			o_acc_feed <= RES_RESET;
		end else begin
			sat <= next_sat;
			frac <= next_frac;
			carry <= next_carry;
			acc <= next_acc;
			size <= next_size;
			res <= next_res;
			sign_extension_word <= next_sign_extension_word;
			cnt <= next_cnt;
			rdata <= next_rdata;
			o_start <= next_start;
			o_start_high <= next_start_high;
			o_op_word <= next_op_word;
			o_acc_feed <= next_acc_feed;
		end
	end

	// Mode outputs mirror the control flops directly.
	assign bus.rdata = rdata;
	assign o_accumulate = acc;
	assign o_size = size;

endmodule : msrp_device

// File: rtl/msrp_host.sv
`timescale 1ns/1ns
module msrp_host (
	input  wire logic                          i_clk,
	input  wire logic                          i_reset,
	msrp_if.host                               bus,
	input  wire logic                          i_req,
	input  wire logic                          i_req_write,
	input  wire logic [msrp_pkg::ADDR_W-1:0]   i_req_addr,
	input  wire logic [msrp_pkg::DATA_W-1:0]   i_req_wdata,
	input  wire logic                          i_pre,
	input  wire logic [msrp_pkg::RES_W-1:0]    i_pre_value,
	output logic                               o_idle,
	output logic [msrp_pkg::DATA_W-1:0]        o_rdata,
	output logic                               o_rvalid,
	output logic                               o_refused
);
	import msrp_pkg::*;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_RD1  = 2'b01,
		HS_RD2  = 2'b10,
		HS_PRE  = 2'b11
	} msrp_hstate_t;

	msrp_hstate_t      state;
	msrp_hstate_t      next_state;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] next_wdata;
	logic              next_wr;
	logic              next_rd;
	logic [DATA_W-1:0] next_rdata;
	logic              next_rvalid;
	logic              next_refused;
	logic [5:0]        shadow;
	logic [5:0]        next_shadow;
	logic              last_wide;
	logic              last_valid;
	logic              next_last_wide;
	logic              next_last_valid;
	logic [RES_W-1:0]  pre;
	logic [RES_W-1:0]  next_pre;
	logic [2:0]        idx;
	logic [2:0]        next_idx;
	logic              op_write;
	logic              mix;

	// Sequencer: one strobe per cycle at most, preloads end with control.
	always_comb begin
		next_state = state;
		next_addr = addr;
		next_wdata = wdata;
		next_wr = 1'b0;
		next_rd = 1'b0;
		next_rdata = o_rdata;
		next_rvalid = 1'b0;
		next_refused = 1'b0;
		next_shadow = shadow;
		next_last_wide = last_wide;
		next_last_valid = last_valid;
		next_pre = pre;
		next_idx = idx;
		op_write = i_req_write && ((i_req_addr == ADDR_OP2_LOW) ||
			(i_req_addr == ADDR_OP2_HIGH));
		mix = last_valid && shadow[CTRL_SAT] && shadow[CTRL_ACC] &&
			(last_wide != (shadow[CTRL_SIZE_HI:CTRL_SIZE_LO] !=
			MSRP_SZ_16X16));
		unique case (state)
			HS_IDLE: begin
				if (i_pre) begin
					next_pre = i_pre_value;
					next_idx = 3'h0;
					next_state = HS_PRE;
				end else if (i_req && op_write && mix) begin
					next_refused = 1'b1; // RL7
				end else if (i_req) begin
					next_addr = i_req_addr;
					next_wdata = i_req_wdata;
					next_wr = i_req_write;
					next_rd = !i_req_write;
					next_state = i_req_write ? HS_IDLE : HS_RD1;
					if (i_req_write && (i_req_addr == ADDR_CTRL)) begin
						next_shadow = i_req_wdata[5:0];
					end
					if (op_write) begin
						next_last_valid = 1'b1;
						next_last_wide = (shadow[CTRL_SIZE_HI:CTRL_SIZE_LO]
							!= MSRP_SZ_16X16);
					end
				end
			end
			HS_RD1: next_state = HS_RD2;
			HS_RD2: begin
				next_rdata = bus.rdata;
				next_rvalid = 1'b1;
				next_state = HS_IDLE;
			end
			HS_PRE: begin
				next_wr = 1'b1;
				next_idx = idx + 3'h1;
				// Only result words are sliced, so the index never runs past
				// the top of the preload value.
				if (idx != 3'h4) begin
					next_addr = ADDR_RESULT_WORD_0 + idx;
					next_wdata = pre[16*idx +: 16];
				end else begin
					// Carry takes the sign of the preloaded value.
					next_addr = ADDR_CTRL;
					next_shadow[CTRL_CARRY] =
						(shadow[CTRL_SIZE_HI:CTRL_SIZE_LO] == MSRP_SZ_16X16)
						? pre[31] : pre[63]; // RL18
					next_wdata = {10'h000, next_shadow};
					next_state = HS_IDLE;
				end
			end
		endcase
	end

	// State registers.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state <= HS_IDLE;
			addr <= ADDR_CTRL;
			wdata <= WORD_RESET;
			wr <= 1'b0;
			rd <= 1'b0;
			o_idle <= 1'b1;
			o_rdata <= WORD_RESET;
			o_rvalid <= 1'b0;
			o_refused <= 1'b0;
			shadow <= 6'h00;
			last_wide <= 1'b0;
			last_valid <= 1'b0;
			pre <= RES_RESET;
			idx <= 3'h0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			wdata <= next_wdata;
			wr <= next_wr;
			rd <= next_rd;
			o_idle <= (next_state == HS_IDLE);
			o_rdata <= next_rdata;
			o_rvalid <= next_rvalid;
			o_refused <= next_refused;
			shadow <= next_shadow;
			last_wide <= next_last_wide;
			last_valid <= next_last_valid;
			pre <= next_pre;
			idx <= next_idx;
		end
	end

	// Bus strobes come straight from flops.
	assign bus.addr = addr;
	assign bus.wdata = wdata;
	assign bus.wr = wr;
	assign bus.rd = rd;

endmodule : msrp_host

// File: verif/msrp_checker.sv
`timescale 1ns/1ns
module msrp_checker (
	input wire logic                        i_clk,
	input wire logic                        i_reset,
	input wire logic [msrp_pkg::ADDR_W-1:0] addr,
	input wire logic [msrp_pkg::DATA_W-1:0] wdata,
	input wire logic                        wr,
	input wire logic                        rd,
	input wire logic [msrp_pkg::DATA_W-1:0] rdata
);
	import msrp_pkg::*;

	logic [DATA_W-1:0] ctrl;
	logic [DATA_W-1:0] next_ctrl;
	logic [CNT_W-1:0]  cnt;
	logic [CNT_W-1:0]  next_cnt;

	// Mirror of the written control bits and of the ready countdown, so the
	// ready bit can be judged without looking inside the device.
	always_comb begin
		next_ctrl = ctrl;
		next_cnt = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_ONE;
		if (wr && addr == ADDR_CTRL) begin
			next_ctrl = wdata;
		end
		if (wr && addr == ADDR_OP2_LOW) begin
			next_cnt = ctrl[CTRL_SIZE_HI] ?
				(ctrl[CTRL_SIZE_LO] ? LAT_32X32_LOW : LAT_16X32_LOW) :
				(ctrl[CTRL_SIZE_LO] ? LAT_32X16 : LAT_16X16);
		end
		if (wr && addr == ADDR_OP2_HIGH && ctrl[CTRL_SIZE_HI]) begin
			next_cnt = ctrl[CTRL_SIZE_LO] ? LAT_32X32_HIGH : LAT_16X32_HIGH;
		end
	end

	// Registers of the mirror.
	always_ff @(posedge i_clk) begin
		ctrl <= i_reset ? WORD_RESET : next_ctrl;
		cnt <= i_reset ? CNT_ZERO : next_cnt;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	chk_one_strobe:
		assert property (!(wr && rd)) else $error("two strobes at once");
	chk_rdata_idle:
		assert property (!rd |=> rdata == ALL_ZERO)
		else $error("read data outside its cycle");
	chk_rd_single:
		assert property (rd |=> !rd) else $error("read strobe too long");
	chk_rd_gap:
		assert property (rd |-> ##2 !rd) else $error("reads too close");
	chk_ctrl_back:
		assert property (rd && addr == ADDR_CTRL |=>
			rdata[1:0] == ctrl[1:0] && rdata[5:3] == ctrl[5:3])
		else $error("control bits read back wrong");
	chk_op_zero:
		assert property (rd && (addr == ADDR_OP2_LOW ||
			addr == ADDR_OP2_HIGH) |=> rdata == ALL_ZERO)
		else $error("operand word not read as zero");
	chk_busy_flag:
		assert property (rd && addr == ADDR_CTRL && cnt != CNT_ZERO |=>
			!rdata[CTRL_READY]) else $error("ready too early");
	chk_ready_flag:
		assert property (rd && addr == ADDR_CTRL && cnt == CNT_ZERO |=>
			rdata[CTRL_READY]) else $error("ready missing");
endmodule : msrp_checker

// File: verif/multiplier_saturation_read_path_tb.sv
`timescale 1ns/1ns
module multiplier_saturation_read_path_tb;
	import msrp_pkg::*;

	logic        i_clk       = 1'b0;
	logic        i_reset     = 1'b1;
	logic        i_req       = 1'b0;
	logic        i_req_write = 1'b0;
	logic [2:0]  i_req_addr  = 3'h0;
	logic [15:0] i_req_wdata = 16'h0000;
	logic        i_pre       = 1'b0;
	logic [63:0] i_pre_value = 64'h0;
	logic        i_res_valid = 1'b0;
	logic [63:0] i_res_value = 64'h0;
	logic        i_res_carry = 1'b0;
	logic [15:0] i_res_sign_extension_word = 16'h0000;
	logic        o_start;
	logic [63:0] o_acc_feed;
	logic        o_idle;
	logic [15:0] o_rdata;
	logic        o_rvalid;
	logic        o_refused;
	logic [63:0] feed_seen;
	logic        o_start_high;
	logic [15:0] o_op_word;
	logic        o_accumulate;
	msrp_size_t  o_size;
	logic [15:0] op_seen;
	logic        high_seen;
	int          starts = 0;
	int          fails = 0;
	int          compares = 0;

	msrp_if msrp_if_i ();
	msrp_device msrp_device_i (.i_clk(i_clk), .i_reset(i_reset),
		.bus(msrp_if_i), .i_res_valid(i_res_valid),
		.i_res_value(i_res_value), .i_res_carry(i_res_carry),
		.i_res_sign_extension_word(i_res_sign_extension_word), .o_start(o_start),
		.o_start_high(o_start_high), .o_op_word(o_op_word),
		.o_accumulate(o_accumulate), .o_size(o_size),
		.o_acc_feed(o_acc_feed));
	msrp_host msrp_host_i (.i_clk(i_clk), .i_reset(i_reset),
		.bus(msrp_if_i), .i_req(i_req), .i_req_write(i_req_write),
		.i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .i_pre(i_pre),
		.i_pre_value(i_pre_value), .o_idle(o_idle), .o_rdata(o_rdata),
		.o_rvalid(o_rvalid), .o_refused(o_refused));
	msrp_checker msrp_checker_i (.i_clk(i_clk), .i_reset(i_reset),
		.addr(msrp_if_i.addr), .wdata(msrp_if_i.wdata), .wr(msrp_if_i.wr),
		.rd(msrp_if_i.rd), .rdata(msrp_if_i.rdata));

	always #10 i_clk = ~i_clk;

	// Launches are single-cycle pulses, so they are caught here.
	always @(posedge i_clk) begin
		if (o_start) begin
			feed_seen <= o_acc_feed;
			op_seen <= o_op_word;
			high_seen <= o_start_high;
			starts <= starts + 1;
		end
	end

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One host request; the data lines are scrambled once released.
	task automatic access(input logic p, input logic w, input logic [2:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic r);
		q = 16'hxxxx;
		r = 1'b0;
		@(posedge i_clk);
		i_req <= ~p;
		i_pre <= p;
		i_req_write <= w;
		i_req_addr <= a;
		i_req_wdata <= d;
		@(posedge i_clk);
		i_req <= 1'b0;
		i_pre <= 1'b0;
		i_req_wdata <= ~d;
		for (int n = 0; n < 24; n++) begin
			#1;
			if (o_rvalid) q = o_rdata;
			if (o_refused) r = 1'b1;
			if (n > 2 && o_idle) break;
			@(posedge i_clk);
		end
	endtask : access

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		logic [15:0] q;
		logic        r;
		access(1'b0, 1'b1, a, d, q, r);
	endtask : wr

	task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
		logic [15:0] q;
		logic        r;
		access(1'b0, 1'b0, a, 16'h0000, q, r);
		check($sformatf("word at %0d", a), {48'h0, q}, {48'h0, e});
	endtask : rd_chk

	// Datapath stores a new result, carry and sign extension.
	task automatic load(input logic [63:0] v, input logic c);
		@(posedge i_clk);
		i_res_valid <= 1'b1;
		i_res_value <= v;
		i_res_carry <= c;
		i_res_sign_extension_word <= 16'h0001;
		@(posedge i_clk);
		i_res_valid <= 1'b0;
		i_res_value <= ~v;
	endtask : load

	task automatic t_sat32();
		wr(ADDR_CTRL, 16'h0001);
		load(64'h5555_6666_8000_1234, 1'b0);
		rd_chk(ADDR_RESULT_WORD_1, 16'h7fff);
		rd_chk(ADDR_RESULT_WORD_0, 16'hffff);
		rd_chk(ADDR_RESULT_WORD_2, 16'h6666);
		rd_chk(ADDR_SIGN_EXTENSION_WORD, 16'h0001);
		wr(ADDR_SIGN_EXTENSION_WORD, 16'h00f0);
		rd_chk(ADDR_SIGN_EXTENSION_WORD, 16'h00f0);
		rd_chk(ADDR_CTRL, 16'h0041);
		wr(ADDR_CTRL, 16'h0000);
		rd_chk(ADDR_RESULT_WORD_1, 16'h8000);
		rd_chk(ADDR_RESULT_WORD_0, 16'h1234);
		wr(ADDR_CTRL, 16'h0001);
		load(64'h5555_6666_1234_0000, 1'b1);
		rd_chk(ADDR_RESULT_WORD_1, 16'h8000);
		rd_chk(ADDR_RESULT_WORD_0, 16'h0000);
		rd_chk(ADDR_RESULT_WORD_3, 16'h5555);
	endtask : t_sat32

	task automatic t_sat64();
		int s0;
		wr(ADDR_CTRL, 16'h0031);
		load(64'h8000_0000_0000_0001, 1'b0);
		rd_chk(ADDR_RESULT_WORD_3, 16'h7fff);
		rd_chk(ADDR_RESULT_WORD_0, 16'hffff);
		load(64'h1234_0000_0000_0000, 1'b1);
		rd_chk(ADDR_RESULT_WORD_3, 16'h8000);
		rd_chk(ADDR_RESULT_WORD_1, 16'h0000);
		// A high-word write launches only when the second operand is wide.
		wr(ADDR_CTRL, 16'h0021);
		wr(ADDR_OP2_HIGH, 16'h00a5);
		check("launch high", {63'h0, high_seen}, 64'h1);
		check("launch word", {48'h0, op_seen}, 64'h00a5);
		s0 = starts;
		wr(ADDR_CTRL, 16'h0011);
		wr(ADDR_OP2_HIGH, 16'h005a);
		check("no launch", 64'(starts), 64'(s0));
	endtask : t_sat64

	task automatic t_frac();
		wr(ADDR_CTRL, 16'h0003);
		load(64'h0000_0000_4000_0000, 1'b0);
		rd_chk(ADDR_RESULT_WORD_1, 16'h7fff);
		rd_chk(ADDR_RESULT_WORD_0, 16'hffff);
		load(64'h0000_0000_8000_0000, 1'b1);
		rd_chk(ADDR_RESULT_WORD_1, 16'h8000);
		wr(ADDR_CTRL, 16'h0002);
		load(64'h0000_0000_1234_5678, 1'b1);
		rd_chk(ADDR_RESULT_WORD_0, 16'hacf0);
		rd_chk(ADDR_RESULT_WORD_1, 16'h2468);
		rd_chk(ADDR_CTRL, 16'h0046);
	endtask : t_frac

	task automatic t_feed();
		logic [15:0] q;
		logic        r;
		int          s0;
		wr(ADDR_CTRL, 16'h0039);
		check("mode", {61'h0, o_accumulate, o_size}, 64'h7);
		load(64'h8000_0000_0000_0000, 1'b0);
		s0 = starts;
		wr(ADDR_OP2_LOW, 16'h0002);
		check("feed", feed_seen, 64'h7fff_ffff_ffff_ffff);
		check("launch low", {63'h0, high_seen}, 64'h0);
		check("launch word", {48'h0, op_seen}, 64'h0002);
		rd_chk(ADDR_RESULT_WORD_3, 16'h8000);
		rd_chk(ADDR_CTRL, 16'h0039);
		repeat (12) @(posedge i_clk);
		rd_chk(ADDR_RESULT_WORD_3, 16'h7fff);
		rd_chk(ADDR_CTRL, 16'h0079);
		rd_chk(ADDR_OP2_LOW, 16'h0000);
		wr(ADDR_CTRL, 16'h0009);
		access(1'b0, 1'b1, ADDR_OP2_LOW, 16'h0003, q, r);
		check("refused", {63'h0, r}, 64'h1);
		wr(ADDR_CTRL, 16'h0008);
		wr(ADDR_OP2_LOW, 16'h0003);
		wr(ADDR_CTRL, 16'h0009);
		load(64'h1111_2222_8000_0000, 1'b0);
		wr(ADDR_OP2_HIGH, 16'h0004);
		wr(ADDR_OP2_LOW, 16'h0004);
		check("starts", 64'(starts), 64'(s0 + 3));
		check("feed", feed_seen, 64'h1111_2222_7fff_ffff);
	endtask : t_feed

	task automatic t_preload();
		logic [15:0] q;
		logic        r;
		wr(ADDR_CTRL, 16'h0001);
		@(posedge i_clk);
		i_pre_value <= 64'h0000_0000_8000_0000;
		access(1'b1, 1'b0, ADDR_CTRL, 16'h0000, q, r);
		rd_chk(ADDR_CTRL, 16'h0045);
		rd_chk(ADDR_RESULT_WORD_1, 16'h8000);
	endtask : t_preload

	task automatic report_and_stop();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	// Main sequence: hold reset, then run every scenario once.
	initial begin
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
		rd_chk(ADDR_CTRL, 16'h0040);
		t_sat32();
		t_sat64();
		t_frac();
		t_feed();
		t_preload();
		report_and_stop();
	end

	// The scenarios need well under a thousand cycles.
	initial begin
		#60000;
		fails++;
		report_and_stop();
	end
endmodule : multiplier_saturation_read_path_tb
